//--- src/sddc_top.sv
// Solution valve duty-cycle and detergent pump stroke controller with AXI4-Lite registers
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - The valve repeats a six-second period and is on for the duty percentage of it.
// - A duty of one hundred percent keeps the valve on with no off interval.
// - The duty is taken from the selected flow setting and follows it when it changes.
// - The valve output is a low-side switch, high here meaning pulled to ground and open.
// - The valve is on only with no fault, no low voltage, scrub on, deck down and motion.
// - The pump runs under the same conditions plus detergent installed and enabled.
// - While stationary the valve output is left open.
// - With the solution function disabled the valve output stays open whatever motion says.
// - Pump strokes alternate the polarity across the coil, one stroke per reversal.
// - The stroke rate per minute comes from deck type, flow setting and detergent ratio.
// - With the detergent function off neither pump output is driven.
// - Each pump pulse lasts 110 ms unless the pump enable drops mid-stroke, at most about 3.5 pulses per second.
module sddc_top
  import sddc_pkg::*;
#(
  parameter int MS_CYCLES = SDDC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Machine status pins
  input  wire logic        major_fault,
  input  wire logic        low_voltage,
  input  wire logic        deck_below_vac_switch,
  input  wire logic        motion_n,
  // Coil drives
  output logic             solution_valve_sink,
  output logic             detergent_pump_fwd,
  output logic             detergent_pump_back
);

  // Stroke rate from deck, flow and ratio, capped at the pulse ceiling
  function automatic logic [7:0] stroke_rate(input logic deck, input logic [1:0] flow,
                                             input logic [1:0] ratio);
    logic [11:0] r;
    logic [1:0]  f;
    f = (flow == 2'h3) ? 2'h2 : flow;
    r = 12'(deck ? SDDC_BASE_FAST : SDDC_BASE_DISK) * 12'({2'h0, f} + 4'h1)
        * 12'({2'h0, ratio} + 4'h1);
    if (r > 12'(SDDC_MAX_RATE)) r = 12'(SDDC_MAX_RATE);
    return r[7:0];
  endfunction : stroke_rate

  // On-time of the valve in ms for a duty percentage
  function automatic logic [12:0] duty_ms(input logic [7:0] pct);
    duty_ms = (pct >= 8'(SDDC_FULL_PCT)) ? 13'(SDDC_VALVE_PERIOD_MS) : 13'(pct * 60);
  endfunction : duty_ms

  sddc_ctrl_s  ctrl_q;
  logic [31:0] duty_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [12:0] phase_ms_q;
  logic        base_en;
  logic        valve_en;
  logic        pump_en;
  logic [7:0]  duty_pct;
  logic [7:0]  rate;
  logic [16:0] acc_q;
  logic [16:0] acc_sum;
  logic        due_q;
  logic        pulse_q;
  logic [7:0]  pulse_ms_q;
  logic [8:0]  space_ms_q;
  logic        pol_q;
  logic        valve_q;
  logic        fwd_q;
  logic        back_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        do_write;

  // Two-stage synchronisers on the machine pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'hb;
      sync2_q <= 4'hb;
    end else begin
      sync1_q <= {motion_n, deck_below_vac_switch, low_voltage, major_fault};
      sync2_q <= sync1_q;
    end
  end

  // Enable gates; motion is active low on the pin
  assign base_en  = !sync2_q[0] && !sync2_q[1] && ctrl_q.scrub_en && sync2_q[2]
                    && !sync2_q[3];
  assign valve_en = base_en && ctrl_q.solution_en;
  assign pump_en  = base_en && ctrl_q.det_installed && ctrl_q.det_enable;

  // Millisecond tick shared by valve and pump timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q == 32'(MS_CYCLES - 1));

  // Free-running six-second valve phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ms_q <= 13'h0;
    end else if (tick) begin
      phase_ms_q <= (phase_ms_q == 13'(SDDC_VALVE_PERIOD_MS - 1)) ? 13'h0
                    : phase_ms_q + 13'h1;
    end
  end

  // Duty picked from the active flow setting; setting 3 acts as high
  always_comb begin
    case (ctrl_q.flow_sel)
      2'h0:    duty_pct = duty_q[7:0];
      2'h1:    duty_pct = duty_q[15:8];
      default: duty_pct = duty_q[23:16];
    endcase
  end

  // Valve sink; full duty never meets the off compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valve_q <= 1'b0;
    end else begin
      valve_q <= valve_en && (phase_ms_q < duty_ms(duty_pct));
    end
  end

  // Stroke scheduler; an accumulator avoids a divider for 60 s / rate
  assign rate    = stroke_rate(ctrl_q.deck_type, ctrl_q.flow_sel, ctrl_q.det_ratio);
  assign acc_sum = acc_q + {9'h0, rate};
  always_ff @(posedge aclk) begin
    if (!aresetn || !pump_en) begin
      acc_q <= 17'h0;
    end else if (tick) begin
      acc_q <= (acc_sum >= 17'(SDDC_MINUTE_MS)) ? acc_sum - 17'(SDDC_MINUTE_MS)
               : acc_sum;
    end
  end

  // A due stroke waits for the spacing window instead of being dropped
  always_ff @(posedge aclk) begin
    if (!aresetn || !pump_en) begin
      due_q <= 1'b0;
    end else if (tick && acc_sum >= 17'(SDDC_MINUTE_MS)) begin
      due_q <= 1'b1;
    end else if (tick && !pulse_q && due_q && space_ms_q == 9'h0) begin
      due_q <= 1'b0;
    end
  end

  // Pulse timers; a pulse starts on a tick so its width is whole milliseconds
  always_ff @(posedge aclk) begin
    if (!aresetn || !pump_en) begin
      pulse_q    <= 1'b0;
      pulse_ms_q <= 8'h0;
      space_ms_q <= 9'h0;
    end else if (tick && !pulse_q && due_q && space_ms_q == 9'h0) begin
      pulse_q    <= 1'b1;
      pulse_ms_q <= 8'h0;
      space_ms_q <= 9'(SDDC_PULSE_SPACE_MS);
    end else if (tick) begin
      if (pulse_q && pulse_ms_q == 8'(SDDC_PULSE_WIDTH_MS - 1)) begin
        pulse_q <= 1'b0;
      end
      pulse_ms_q <= pulse_ms_q + 8'h1;
      if (space_ms_q != 9'h0) begin
        space_ms_q <= space_ms_q - 9'h1;
      end
    end
  end

  // Polarity flips at each pulse end, kept across enable drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q <= 1'b0;
    end else if (pulse_q && (!pump_en || (tick &&
                 pulse_ms_q == 8'(SDDC_PULSE_WIDTH_MS - 1)))) begin
      pol_q <= !pol_q;
    end
  end

  // Bridge legs; never both, nothing when pump is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_q  <= 1'b0;
      back_q <= 1'b0;
    end else begin
      fwd_q  <= pump_en && pulse_q && !pol_q;
      back_q <= pump_en && pulse_q && pol_q;
    end
  end

  assign solution_valve_sink = valve_q;
  assign detergent_pump_fwd  = fwd_q;
  assign detergent_pump_back = back_q;

  // AXI write: address and data latched independently
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign do_write      = aw_held_q && w_held_q && !bvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register writes with byte lanes; unmapped answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= SDDC_CTRL_RST[8:0];
      duty_q   <= SDDC_DUTY_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= 2'h0;
        case (awaddr_q & 4'hc)
          SDDC_CTRL_OFS: begin
            if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) ctrl_q[8]   <= wdata_q[SDDC_CTRL_DECK_BIT];
          end
          SDDC_DUTY_OFS: begin
            for (int i = 0; i < 3; i++) begin
              if (wstrb_q[i]) duty_q[8*i +: 8] <= wdata_q[8*i +: 8];
            end
          end
          SDDC_STATUS_OFS, SDDC_RATE_OFS: bresp_q <= 2'h0;
          default: bresp_q <= 2'h2;
        endcase
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // AXI read, one cycle after the address is taken
  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= 2'h0;
      case (s_axi_araddr & 4'hc)
        SDDC_CTRL_OFS:   rdata_q <= {23'h0, ctrl_q};
        SDDC_DUTY_OFS:   rdata_q <= {8'h0, duty_q[23:0]};
        SDDC_STATUS_OFS: rdata_q <= {22'h0, back_q, fwd_q, valve_q, pump_en, valve_en,
                                     base_en, sync2_q};
        SDDC_RATE_OFS:   rdata_q <= {24'h0, rate};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [1:0] last_leg_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_leg_q <= 2'h0;
    end else if (fwd_q) begin
      last_leg_q <= 2'h1;
    end else if (back_q) begin
      last_leg_q <= 2'h2;
    end
  end

  valve_gate_a: assert property (!valve_en |=> !solution_valve_sink)
    else $error("valve on without enable");
  valve_duty_a: assert property (solution_valve_sink |->
    $past(phase_ms_q) < duty_ms($past(duty_pct)))
    else $error("valve on outside duty window");
  valve_full_a: assert property ((valve_en && duty_pct >= 8'(SDDC_FULL_PCT)) [*2]
    |=> solution_valve_sink)
    else $error("full duty valve off");
  phase_range_a: assert property (phase_ms_q < 13'(SDDC_VALVE_PERIOD_MS))
    else $error("valve phase out of period");
  pump_gate_a: assert property (!pump_en |=> !detergent_pump_fwd && !detergent_pump_back)
    else $error("pump driven while disabled");
  pump_legs_a: assert property (!(detergent_pump_fwd && detergent_pump_back))
    else $error("both pump legs on");
  pump_alt_a: assert property ($rose(detergent_pump_fwd) && last_leg_q != 2'h0
    |-> last_leg_q == 2'h2)
    else $error("pump polarity did not alternate");
  pulse_end_a: assert property (pulse_q && tick &&
    pulse_ms_q == 8'(SDDC_PULSE_WIDTH_MS - 1) |=> !pulse_q ##1
    (!detergent_pump_fwd && !detergent_pump_back))
    else $error("pump pulse overran width");
  rate_cap_a: assert property (rate <= 8'(SDDC_MAX_RATE))
    else $error("stroke rate above ceiling");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  valve_on_c: cover property (valve_en ##1 solution_valve_sink);
  pump_fwd_c: cover property ($rose(detergent_pump_fwd));
  pump_back_c: cover property ($rose(detergent_pump_back));
  drop_c:     cover property (pulse_q && !pump_en);

endmodule : sddc_top

//--- src/sddc_pkg.sv
// Package for the solution and detergent dosing controller: register map, fields, timing
package sddc_pkg;
  // Register byte offsets
  localparam logic [3:0] SDDC_CTRL_OFS   = 4'h0;
  localparam logic [3:0] SDDC_DUTY_OFS   = 4'h4;
  localparam logic [3:0] SDDC_STATUS_OFS = 4'h8;
  localparam logic [3:0] SDDC_RATE_OFS   = 4'hc;
  // Control field positions
  localparam int SDDC_CTRL_SCRUB_BIT = 0;
  localparam int SDDC_CTRL_SOL_BIT   = 1;
  localparam int SDDC_CTRL_DINST_BIT = 2;
  localparam int SDDC_CTRL_DEN_BIT   = 3;
  localparam int SDDC_CTRL_FLOW_LSB  = 4;
  localparam int SDDC_CTRL_RATIO_LSB = 6;
  localparam int SDDC_CTRL_DECK_BIT  = 8;
  // Reset values
  localparam logic [31:0] SDDC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SDDC_DUTY_RST = 32'h0064_3219;
  // Timing in own units
  localparam int SDDC_CLK_PERIOD_NS   = 4;
  localparam int SDDC_MS_NS           = 1000000;
  localparam int SDDC_MS_CYCLES       = (SDDC_MS_NS + SDDC_CLK_PERIOD_NS - 1) / SDDC_CLK_PERIOD_NS;
  localparam int SDDC_VALVE_PERIOD_S  = 6;
  localparam int SDDC_VALVE_PERIOD_MS = SDDC_VALVE_PERIOD_S * 1000;
  localparam int SDDC_PULSE_WIDTH_MS  = 110;
  localparam int SDDC_PULSE_FREQ_MHZ  = 3500;
  localparam int SDDC_PULSE_SPACE_MS  = 1000000 / SDDC_PULSE_FREQ_MHZ;
  localparam int SDDC_MINUTE_MS       = 60000;
  localparam int SDDC_MAX_RATE        = SDDC_PULSE_FREQ_MHZ * 60 / 1000;
  localparam int SDDC_FULL_PCT        = 100;
  // Stroke base per deck type, strokes per minute
  localparam logic [7:0] SDDC_BASE_DISK = 8'h10;
  localparam logic [7:0] SDDC_BASE_FAST = 8'h08;
  // Software control word
  typedef struct packed {
    logic       deck_type;
    logic [1:0] det_ratio;
    logic [1:0] flow_sel;
    logic       det_enable;
    logic       det_installed;
    logic       solution_en;
    logic       scrub_en;
  } sddc_ctrl_s;
endpackage : sddc_pkg

//--- tb/sddc_coil_model.sv
// Behavioural valve coil and pump coil that watch the coil drives
`timescale 1ns/10ps
module sddc_coil_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Coil drives
  input  wire logic valve_sink,
  input  wire logic pump_fwd,
  input  wire logic pump_back,
  // Observations for the bench
  output int        valve_on,
  output int        pulses,
  output int        last_width,
  output int        bad_cnt
);
  int   run;
  logic fwd_last;

  // Valve is energized for every cycle the low-side switch conducts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valve_on <= 0;
    end else if (valve_sink) begin
      valve_on <= valve_on + 1;
    end
  end

  // Pump coil: stroke count, stroke width, polarity and shorted drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run        <= 0;
      pulses     <= 0;
      last_width <= 0;
      bad_cnt    <= 0;
      fwd_last   <= 1'b0;
    end else begin
      if (pump_fwd && pump_back) begin
        bad_cnt <= bad_cnt + 1;
      end
      if (pump_fwd || pump_back) begin
        run <= run + 1;
        if (run == 0) begin
          pulses   <= pulses + 1;
          fwd_last <= pump_fwd;
          // A stroke in the same direction as the last one moves nothing
          if (pump_fwd == fwd_last) begin
            bad_cnt <= bad_cnt + 1;
          end
        end
      end else if (run != 0) begin
        last_width <= run;
        run        <= 0;
      end
    end
  end
endmodule : sddc_coil_model

//--- tb/sddc_top_tb.sv
// Self-checking bench for the solution and detergent dosing controller
`timescale 1ns/10ps
module sddc_top_tb
  import sddc_pkg::*;
;
  localparam int         MS      = 4;
  localparam logic [3:0] PINS_OK = 4'h2; // Fault, low voltage, deck, motion_n
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        major_fault, low_voltage, deck_below_vac_switch, motion_n;
  logic        solution_valve_sink, detergent_pump_fwd, detergent_pump_back;
  int          valve_on, pulses, last_width, bad_cnt, n_fail, n_checks, cyc, t0;

  sddc_top #(.MS_CYCLES(MS)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .major_fault, .low_voltage, .deck_below_vac_switch, .motion_n,
    .solution_valve_sink, .detergent_pump_fwd, .detergent_pump_back);

  sddc_coil_model coil (.aclk, .aresetn, .valve_sink(solution_valve_sink),
    .pump_fwd(detergent_pump_fwd), .pump_back(detergent_pump_back), .valve_on,
    .pulses, .last_width, .bad_cnt);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'h0, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic t_regs;
    rd(SDDC_CTRL_OFS, rd_d);
    chk("ctrl_rst", SDDC_CTRL_RST, rd_d);
    rd(SDDC_DUTY_OFS, rd_d);
    chk("duty_rst", SDDC_DUTY_RST, rd_d);
    wr(SDDC_CTRL_OFS, 32'h0000_01ff);
    rd(SDDC_CTRL_OFS, rd_d);
    chk("ctrl_rw", 32'h0000_01ff, rd_d);
    $display("t_regs done");
  endtask : t_regs

  // One full six-second window per flow setting gives an exact on count
  task automatic t_valve;
    for (int f = 0; f < 3; f++) begin
      wr(SDDC_CTRL_OFS, 32'h3 | (f << 4));
      repeat (8) @(posedge aclk);
      t0 = valve_on;
      repeat (6000 * MS) @(posedge aclk);
      chk("valve_on", SDDC_DUTY_RST[8*f +: 8] * 60 * MS, valve_on - t0);
    end
    $display("t_valve done");
  endtask : t_valve

  // Full flow keeps the valve on, so every drop of an enable must show
  task automatic t_gate;
    logic [3:0] p;
    wr(SDDC_CTRL_OFS, 32'h2f);
    for (int i = 0; i < 4; i++) begin
      p = PINS_OK ^ (4'h1 << i);
      {major_fault, low_voltage, deck_below_vac_switch, motion_n} <= p;
      repeat (4) @(posedge aclk);
      chk("gated", 32'h0, {29'h0, solution_valve_sink, detergent_pump_fwd,
                           detergent_pump_back});
      {major_fault, low_voltage, deck_below_vac_switch, motion_n} <= PINS_OK;
      repeat (4) @(posedge aclk);
      chk("valve", 32'h1, {31'h0, solution_valve_sink});
    end
    wr(SDDC_CTRL_OFS, 32'h2d);
    repeat (4) @(posedge aclk);
    chk("sol_off", 32'h0, {31'h0, solution_valve_sink});
    $display("t_gate done");
  endtask : t_gate

  task automatic t_pump;
    wr(SDDC_CTRL_OFS, 32'h16f);
    rd(SDDC_RATE_OFS, rd_d);
    chk("rate_fast", 32'd48, rd_d);
    wr(SDDC_CTRL_OFS, 32'hff);
    rd(SDDC_RATE_OFS, rd_d);
    chk("rate_max", 32'd192, rd_d);
    t0 = pulses;
    repeat (3000 * MS) @(posedge aclk);
    chk("strokes", 32'h1, {31'h0, (pulses - t0 >= 9) && (pulses - t0 <= 10)});
    chk("width", SDDC_PULSE_WIDTH_MS * MS, last_width);
    chk("polarity", 32'h0, bad_cnt);
    wr(SDDC_CTRL_OFS, 32'hf7);
    repeat (4) @(posedge aclk);
    t0 = pulses;
    repeat (1500 * MS) @(posedge aclk);
    chk("det_off", 32'h0, pulses - t0);
    $display("t_pump done");
  endtask : t_pump

  // A fault in mid-stroke must cut the stroke short
  task automatic t_abort;
    wr(SDDC_CTRL_OFS, 32'hff);
    while (!(detergent_pump_fwd || detergent_pump_back)) @(posedge aclk);
    repeat (40) @(posedge aclk);
    major_fault <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("abort", 32'h0, {30'h0, detergent_pump_fwd, detergent_pump_back});
    major_fault <= 1'b0;
    $display("t_abort done");
  endtask : t_abort

  // Reset in mid-run clears the control word and every coil drive
  task automatic t_rst;
    wr(SDDC_CTRL_OFS, 32'hff);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("rst_out", 32'h0, {29'h0, solution_valve_sink, detergent_pump_fwd,
                           detergent_pump_back});
    aresetn <= 1'b1;
    rd(SDDC_CTRL_OFS, rd_d);
    chk("rst_ctrl", SDDC_CTRL_RST, rd_d);
    $display("t_rst done");
  endtask : t_rst

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Hang guard, sized a little above the longest expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      $display("timeout at cycle %0d", cyc);
      summarize();
    end
  end

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {major_fault, low_voltage, deck_below_vac_switch, motion_n} = PINS_OK;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_valve();
    t_gate();
    t_pump();
    t_abort();
    t_rst();
    summarize();
  end
endmodule : sddc_top_tb
